/* File: hdl/asp_consts.svh */
/*
 * Register map, field positions, reset values and timing counts of the
 * asynchronous serial port.
 * Assumes it is included by its bare name; its guard allows repeated inclusion per unit.
 */
//
// Behaviour
// RL1: 8-bit mode frame: start bit, eight data bits LSB first, stop bit.
// RL2: Frames leave on the serial out pin and arrive on the serial in pin.
// RL3: 8-bit mode: data goes to receive buffer, stop bit to ninth-bit flag.
// RL4: Writing the data buffer starts sending that byte as a new frame.
// RL5: Transmit-done sets when the stop bit time begins.
// RL6: Receiver starts frames only while receive enable is one.
// RL7: 8-bit mode stores only if receive-done clear and, with check, stop is one.
// RL8: Storing loads buffer, ninth flag and sets receive-done; else nothing.
// RL9: Interrupt request is raised while a done flag is set and enabled.
// RL10: Each overflow of the selected timer clocks the baud logic once.
// RL11: Transmit and receive pick 16-bit or 8-bit timer independently.
// RL12: Either select bit runs the 16-bit timer from system clock over two.
// RL13: 8-bit timer baud is overflow rate times two-to-doubler over 32.
// RL14: 16-bit timer baud is clock over 32 times (65536 minus reload).
// RL15: 9-bit mode frame: start, eight data LSB first, ninth bit, stop.
// RL16: 9-bit mode sends the transmit ninth-bit flag as ninth bit.
// RL17: 9-bit mode keeps received ninth bit and ignores the stop bit.
// RL18: 9-bit mode stores if done clear and, with check, ninth and address.
// RL19: 9-bit mode baud is clock over 64, or over 32 with doubler.
// RL20: Done flags stay set until software writes them to zero.
// RL21: Receiver finds the falling start edge and samples bit centres.
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

`define ASP_ADDR_CTRL 8'h00
`define ASP_ADDR_DATA 8'h04
`define ASP_ADDR_RELOAD8 8'h08
`define ASP_ADDR_RELOAD16 8'h0C
`define ASP_ADDR_OWN 8'h10

`define ASP_BIT_TX_DONE 0
`define ASP_BIT_RX_DONE 1
`define ASP_BIT_TX_NINTH 3
`define ASP_BIT_RX_ENABLE 4
`define ASP_BIT_MP_CHECK 5
`define ASP_BIT_MODE9 6
`define ASP_BIT_IRQ_EN 7
`define ASP_BIT_DOUBLER 8
`define ASP_BIT_TX_CLK_SEL 9
`define ASP_BIT_RX_CLK_SEL 10
`define ASP_BIT_TIMER_CLK_SEL 11

`define ASP_PIN_IDLE 1'b1
`define ASP_OS_LAST 4'hF
`define ASP_OS_MID 4'h7
`define ASP_PRESCALE_LAST 4'hB
`define ASP_STOP_IDX8 4'h9
`define ASP_STOP_IDX9 4'hA
`define ASP_DATA_BITS8 4'h8
`define ASP_DATA_BITS9 4'h9
`define ASP_TOP8 8'hFF
`define ASP_TOP16 16'hFFFF

`endif

/* File: hdl/asp_pkg.sv */
/*
 * Types shared by the serial port and its baud timers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package asp_pkg;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
        asp_rx_state_type;

    typedef struct packed {
        logic [3:0] pre;
        logic [7:0] cnt8;
        logic ovf8;
        logic half16;
        logic [15:0] cnt16;
        logic ovf16;
    } asp_baud_state_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic tx_done;
        logic rx_done;
        logic rx_ninth;
        logic tx_ninth;
        logic rx_enable;
        logic mp_check;
        logic mode9;
        logic irq_en;
        logic doubler;
        logic tx_clk_sel;
        logic rx_clk_sel;
        logic timer_clk_sel;
        logic [7:0] reload8;
        logic [15:0] reload16;
        logic [7:0] own_addr;
        logic [7:0] rx_buf;
        logic half8;
        logic [1:0] fixed_div;
        logic tx_busy;
        logic [10:0] tx_shift;
        logic [3:0] tx_bits;
        logic [3:0] tx_os;
        logic tx_pin;
        asp_rx_state_type rx_state;
        logic [3:0] rx_os;
        logic [3:0] rx_bits;
        logic [8:0] rx_shift;
        logic rx_prev;
        logic irq;
    } asp_top_state_type;

endpackage

/* File: hdl/asp_baud_gen.sv */
/*
 * The two baud timers: an 8-bit auto-reload timer and a 16-bit timer in
 * baud-generator operation, each giving a one-cycle overflow pulse.
 * Assumes reload values come from the register file of the serial port.
 */
`include "asp_consts.svh"

module asp_baud_gen
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic timer_clk_sel_in,
    input wire logic wide_run_in,
    input wire logic [7:0] reload8_in,
    input wire logic [15:0] reload16_in,
    output logic ovf8_out,
    output logic ovf16_out
);
    asp_pkg::asp_baud_state_type s_q;
    asp_pkg::asp_baud_state_type s_d;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    always_comb
    begin
        s_d = s_q;
        s_d.ovf8 = 1'b0;
        s_d.ovf16 = 1'b0;
        // The 8-bit timer counts the system clock, or the clock over 12.
        s_d.pre = (s_q.pre == `ASP_PRESCALE_LAST) ? 4'h0 : s_q.pre + 4'h1;
        if (timer_clk_sel_in || s_q.pre == `ASP_PRESCALE_LAST)
        begin
            if (s_q.cnt8 == `ASP_TOP8) // RL10
            begin
                s_d.cnt8 = reload8_in;
                s_d.ovf8 = 1'b1;
            end
            else
            begin
                s_d.cnt8 = s_q.cnt8 + 8'h01;
            end
        end
        // The wide timer steps on every second system clock. While it is
        // stopped it is preset from its reload, so its first period is full.
        s_d.half16 = !s_q.half16;
        if (s_q.half16)
        begin
            if (!wide_run_in) // RL12
            begin
                s_d.cnt16 = reload16_in;
            end
            else if (s_q.cnt16 == `ASP_TOP16) // RL10
            begin
                s_d.cnt16 = reload16_in;
                s_d.ovf16 = 1'b1;
            end
            else
            begin
                s_d.cnt16 = s_q.cnt16 + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign ovf8_out = s_q.ovf8;
    assign ovf16_out = s_q.ovf16;

    a_ovf8_reload: assert property // RL10
        (s_q.ovf8 |-> s_q.cnt8 == $past(reload8_in))
        else $error("8-bit timer did not reload on overflow.");

    a_wide_half_rate: assert property // RL12
        ($changed(s_q.cnt16) |=> $stable(s_q.cnt16))
        else $error("Wide timer stepped on two cycles in a row.");
endmodule

/* File: hdl/asp_serial_port.sv */
/*
 * First asynchronous serial port in its 8-bit variable-rate and 9-bit
 * fixed-rate modes, with an APB register slave.
 * Assumes APB signals and the serial input are synchronous to CLK_SYS_IN.
 */
// The APB slave port and the register offsets were chosen for this implementation.
`include "asp_consts.svh"

module asp_serial_port
(
    input wire logic CLK_SYS_IN,
    input wire logic RESET_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic SERIAL_IN_PIN_IN,
    output logic SERIAL_OUT_PIN_OUT,
    output logic IRQ_OUT
);
    asp_pkg::asp_top_state_type s_q;
    asp_pkg::asp_top_state_type s_d;
    logic ovf8;
    logic ovf16;
    logic access;
    logic wr_fire;
    logic ctrl_wr;
    logic data_wr;
    logic tick8;
    logic tick_fixed;
    logic tx_tick;
    logic rx_tick;
    logic [3:0] frame_last;
    logic [3:0] data_bits;
    logic [7:0] rx_byte;
    logic rx_ninth_val;
    logic store_ok;
    logic [31:0] ctrl_view;

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    asp_baud_gen u_baud
    (
        .clk_in(CLK_SYS_IN),
        .reset_n_in(RESET_N_IN),
        .timer_clk_sel_in(s_q.timer_clk_sel),
        .wide_run_in(s_q.tx_clk_sel || s_q.rx_clk_sel), // RL12
        .reload8_in(s_q.reload8),
        .reload16_in(s_q.reload16),
        .ovf8_out(ovf8),
        .ovf16_out(ovf16)
    );

    assign access = PSEL_IN && PENABLE_IN;
    assign wr_fire = access && s_q.pready && PWRITE_IN && !s_q.pslverr;
    assign ctrl_wr = wr_fire && PADDR_IN == `ASP_ADDR_CTRL;
    assign data_wr = wr_fire && PADDR_IN == `ASP_ADDR_DATA;

    // Bit engines run at sixteen ticks per bit.
    assign tick8 = ovf8 && (s_q.doubler || s_q.half8); // RL13
    assign tick_fixed = s_q.doubler ? s_q.fixed_div[0] : &s_q.fixed_div; // RL19
    assign tx_tick = s_q.mode9 ? tick_fixed :
        (s_q.tx_clk_sel ? ovf16 : tick8); // RL11 RL14
    assign rx_tick = s_q.mode9 ? tick_fixed :
        (s_q.rx_clk_sel ? ovf16 : tick8); // RL11 RL14

    assign frame_last = s_q.mode9 ? `ASP_STOP_IDX9 : `ASP_STOP_IDX8;
    assign data_bits = s_q.mode9 ? `ASP_DATA_BITS9 : `ASP_DATA_BITS8;

    // The received byte sits higher in the shifter when only eight came in.
    assign rx_byte = s_q.mode9 ? s_q.rx_shift[7:0] : s_q.rx_shift[8:1]; // RL3
    assign rx_ninth_val = s_q.mode9 ? s_q.rx_shift[8] : SERIAL_IN_PIN_IN; // RL17

    assign store_ok = !s_q.rx_done && (!s_q.mp_check ||
        (s_q.mode9 ? (s_q.rx_shift[8] && rx_byte == s_q.own_addr)
                   : SERIAL_IN_PIN_IN)); // RL7 RL18

    assign ctrl_view = {19'h00000, s_q.tx_busy, s_q.timer_clk_sel,
        s_q.rx_clk_sel, s_q.tx_clk_sel, s_q.doubler, s_q.irq_en, s_q.mode9,
        s_q.mp_check, s_q.rx_enable, s_q.tx_ninth, s_q.rx_ninth,
        s_q.rx_done, s_q.tx_done};

    always_comb
    begin
        logic tx_set;
        logic rx_set;
        logic mapped;
        logic [31:0] view;
        tx_set = 1'b0;
        rx_set = 1'b0;
        mapped = 1'b1;
        view = 32'h00000000;
        s_d = s_q;

        // Register slave: one wait state, then the answer.
        case (PADDR_IN)
            `ASP_ADDR_CTRL: view = ctrl_view;
            `ASP_ADDR_DATA: view = {24'h000000, s_q.rx_buf};
            `ASP_ADDR_RELOAD8: view = {24'h000000, s_q.reload8};
            `ASP_ADDR_RELOAD16: view = {16'h0000, s_q.reload16};
            `ASP_ADDR_OWN: view = {24'h000000, s_q.own_addr};
            default: mapped = 1'b0;
        endcase
        s_d.pready = access && !s_q.pready;
        s_d.pslverr = s_d.pready && !mapped;
        s_d.prdata = (s_d.pready && !PWRITE_IN) ? view : 32'h00000000;

        if (ctrl_wr)
        begin
            s_d.tx_ninth = PWDATA_IN[`ASP_BIT_TX_NINTH];
            s_d.rx_enable = PWDATA_IN[`ASP_BIT_RX_ENABLE];
            s_d.mp_check = PWDATA_IN[`ASP_BIT_MP_CHECK];
            s_d.mode9 = PWDATA_IN[`ASP_BIT_MODE9];
            s_d.irq_en = PWDATA_IN[`ASP_BIT_IRQ_EN];
            s_d.doubler = PWDATA_IN[`ASP_BIT_DOUBLER];
            s_d.tx_clk_sel = PWDATA_IN[`ASP_BIT_TX_CLK_SEL];
            s_d.rx_clk_sel = PWDATA_IN[`ASP_BIT_RX_CLK_SEL];
            s_d.timer_clk_sel = PWDATA_IN[`ASP_BIT_TIMER_CLK_SEL];
        end
        if (wr_fire && PADDR_IN == `ASP_ADDR_RELOAD8)
        begin
            s_d.reload8 = PWDATA_IN[7:0];
        end
        if (wr_fire && PADDR_IN == `ASP_ADDR_RELOAD16)
        begin
            s_d.reload16 = PWDATA_IN[15:0];
        end
        if (wr_fire && PADDR_IN == `ASP_ADDR_OWN)
        begin
            s_d.own_addr = PWDATA_IN[7:0];
        end

        // Baud prescalers for the 8-bit timer and the fixed rate.
        if (ovf8)
        begin
            s_d.half8 = !s_q.half8;
        end
        s_d.fixed_div = s_q.fixed_div + 2'h1;

        // Transmitter. A write during a frame restarts with the new byte.
        if (data_wr) // RL4
        begin
            s_d.tx_busy = 1'b1;
            s_d.tx_shift = {1'b1, s_q.mode9 ? s_q.tx_ninth : 1'b1,
                PWDATA_IN[7:0], 1'b0}; // RL1 RL15 RL16
            s_d.tx_bits = 4'h0;
            s_d.tx_os = 4'h0;
        end
        else if (s_q.tx_busy && tx_tick)
        begin
            s_d.tx_os = s_q.tx_os + 4'h1;
            if (s_q.tx_os == `ASP_OS_LAST)
            begin
                s_d.tx_shift = {1'b1, s_q.tx_shift[10:1]};
                s_d.tx_bits = s_q.tx_bits + 4'h1;
                if (s_d.tx_bits == frame_last)
                begin
                    tx_set = 1'b1; // RL5
                end
                if (s_q.tx_bits == frame_last)
                begin
                    s_d.tx_busy = 1'b0;
                end
            end
        end
        s_d.tx_pin = s_d.tx_busy ? s_d.tx_shift[0] : `ASP_PIN_IDLE; // RL2

        // Receiver with start validation at mid bit.
        s_d.rx_prev = SERIAL_IN_PIN_IN;
        case (s_q.rx_state)
            asp_pkg::RX_IDLE:
            begin
                if (s_q.rx_enable && s_q.rx_prev && !SERIAL_IN_PIN_IN) // RL6 RL21
                begin
                    s_d.rx_state = asp_pkg::RX_START;
                    s_d.rx_os = 4'h0;
                end
            end
            asp_pkg::RX_START:
            begin
                if (rx_tick)
                begin
                    s_d.rx_os = s_q.rx_os + 4'h1;
                    if (s_q.rx_os == `ASP_OS_MID) // RL21
                    begin
                        s_d.rx_state = SERIAL_IN_PIN_IN ? asp_pkg::RX_IDLE
                                                        : asp_pkg::RX_DATA;
                        s_d.rx_os = 4'h0;
                        s_d.rx_bits = 4'h0;
                    end
                end
            end
            asp_pkg::RX_DATA:
            begin
                if (rx_tick)
                begin
                    s_d.rx_os = s_q.rx_os + 4'h1;
                    if (s_q.rx_os == `ASP_OS_LAST)
                    begin
                        s_d.rx_shift = {SERIAL_IN_PIN_IN, s_q.rx_shift[8:1]};
                        s_d.rx_bits = s_q.rx_bits + 4'h1;
                        if (s_d.rx_bits == data_bits)
                        begin
                            s_d.rx_state = asp_pkg::RX_STOP;
                        end
                    end
                end
            end
            asp_pkg::RX_STOP:
            begin
                if (rx_tick)
                begin
                    s_d.rx_os = s_q.rx_os + 4'h1;
                    if (s_q.rx_os == `ASP_OS_LAST)
                    begin
                        s_d.rx_state = asp_pkg::RX_IDLE;
                        if (store_ok) // RL8
                        begin
                            s_d.rx_buf = rx_byte; // RL3
                            s_d.rx_ninth = rx_ninth_val; // RL3 RL17
                            rx_set = 1'b1;
                        end
                    end
                end
            end
            default:
            begin
                s_d.rx_state = asp_pkg::RX_IDLE;
            end
        endcase

        // Flags: software may only clear them, and a set wins.
        s_d.tx_done = tx_set || (s_q.tx_done &&
            !(ctrl_wr && !PWDATA_IN[`ASP_BIT_TX_DONE])); // RL20
        s_d.rx_done = rx_set || (s_q.rx_done &&
            !(ctrl_wr && !PWDATA_IN[`ASP_BIT_RX_DONE])); // RL20
        s_d.irq = s_d.irq_en && (s_d.tx_done || s_d.rx_done); // RL9
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            s_q <= '0;
            s_q.tx_pin <= `ASP_PIN_IDLE;
            s_q.rx_prev <= `ASP_PIN_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign PRDATA_OUT = s_q.prdata;
    assign PREADY_OUT = s_q.pready;
    assign PSLVERR_OUT = s_q.pslverr;
    assign SERIAL_OUT_PIN_OUT = s_q.tx_pin;
    assign IRQ_OUT = s_q.irq;

    a_tx_idle_high: assert property // RL2
        (!s_q.tx_busy |-> SERIAL_OUT_PIN_OUT)
        else $error("Serial out not high while idle.");

    a_tx_start_bit: assert property // RL4
        (data_wr |=> !SERIAL_OUT_PIN_OUT && s_q.tx_busy && s_q.tx_bits == 4'h0)
        else $error("Data write did not start a frame.");

    a_tx_done_stop: assert property // RL5
        ($rose(s_q.tx_done) |->
            SERIAL_OUT_PIN_OUT && s_q.tx_busy && s_q.tx_bits == frame_last)
        else $error("Transmit done not set at stop bit start.");

    a_rx_gate_idle: assert property // RL6
        (s_q.rx_state == asp_pkg::RX_IDLE && !s_q.rx_enable
            |=> s_q.rx_state == asp_pkg::RX_IDLE)
        else $error("Receiver started while disabled.");

    a_rx_buf_held: assert property // RL7
        (s_q.rx_done |=> $stable(s_q.rx_buf) && $stable(s_q.rx_ninth))
        else $error("Receive buffer changed while receive done set.");

    a_rx_store_stop: assert property // RL8
        ($rose(s_q.rx_done) |-> $past(s_q.rx_state) == asp_pkg::RX_STOP)
        else $error("Receive done set outside stop bit.");

    a_flag_sticky: assert property // RL20
        (s_q.rx_done && !ctrl_wr |=> s_q.rx_done)
        else $error("Receive done cleared without a write.");

    a_irq_follow: assert property // RL9
        (IRQ_OUT == (s_q.irq_en && (s_q.tx_done || s_q.rx_done)))
        else $error("Interrupt request disagrees with flags.");

    a_tx_stop_high: assert property // RL1 RL15
        (s_q.tx_busy && s_q.tx_bits == frame_last |-> SERIAL_OUT_PIN_OUT)
        else $error("Stop bit not high on the serial out pin.");

    a_tx_ninth_load: assert property // RL16
        (data_wr && s_q.mode9 |=> s_q.tx_shift[9] == $past(s_q.tx_ninth))
        else $error("Ninth bit not taken from its control flag.");

    a_tx_wide_src: assert property // RL11 RL14
        (s_q.tx_busy && !s_q.mode9 && s_q.tx_clk_sel && !ovf16 && !data_wr
            |=> $stable(s_q.tx_os))
        else $error("Transmitter stepped without a wide timer overflow.");

    a_rx_narrow_src: assert property // RL11 RL13
        (s_q.rx_state != asp_pkg::RX_IDLE && !s_q.mode9 && !s_q.rx_clk_sel
            && !tick8 |=> $stable(s_q.rx_os))
        else $error("Receiver stepped without an 8-bit timer tick.");

    a_rx_mid_start: assert property // RL21
        (s_q.rx_state == asp_pkg::RX_START && rx_tick &&
            s_q.rx_os == `ASP_OS_MID
            |=> s_q.rx_state != asp_pkg::RX_START && s_q.rx_os == 4'h0)
        else $error("Start bit not decided at its centre.");

    a_rx_load_value: assert property // RL3 RL8
        ($rose(s_q.rx_done) |-> s_q.rx_buf == $past(rx_byte) &&
            s_q.rx_ninth == $past(rx_ninth_val))
        else $error("Receive buffer or ninth flag not loaded on store.");

    a_store_stop_one: assert property // RL7
        ($rose(s_q.rx_done) && !$past(s_q.mode9) && $past(s_q.mp_check)
            |-> s_q.rx_ninth)
        else $error("Byte stored with a low stop bit under the check.");

    a_store_address: assert property // RL18
        ($rose(s_q.rx_done) && $past(s_q.mode9) && $past(s_q.mp_check)
            |-> s_q.rx_ninth && s_q.rx_buf == $past(s_q.own_addr))
        else $error("Byte stored without ninth bit and matching address.");

    a_refused_hold: assert property // RL8
        (s_q.rx_state == asp_pkg::RX_STOP && rx_tick &&
            s_q.rx_os == `ASP_OS_LAST && !store_ok
            |=> $stable(s_q.rx_buf) && $stable(s_q.rx_ninth) &&
            !$rose(s_q.rx_done))
        else $error("Refused byte changed the receive state.");

    a_fixed_tick: assert property // RL19
        (s_q.mode9 && !s_q.doubler && tx_tick |-> &s_q.fixed_div)
        else $error("Fixed rate tick not on every fourth clock.");
endmodule

/* File: testbench/asp_far_port.sv */
/*
 * Model of the remote serial port: sends frames on request and captures
 * every frame it hears.
 * Assumes the line idles high and periods are counted in system clocks.
 */
module asp_far_port
(
    input wire logic clk_in,
    input wire logic line_in,
    input wire logic nine_in,
    input wire logic [15:0] hear_clks_in,
    output logic line_out,
    output logic [7:0] got_byte_out,
    output logic got_ninth_out,
    output logic got_stop_out,
    output logic [7:0] got_cnt_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] sh;

    initial
    begin
        line_out = 1'b1;
        got_cnt_out = 8'h00;
    end

    task automatic send(input logic [7:0] b, input logic n9, stp,
                        input int clks);
        logic [10:0] fr;
        fr = {stp, n9, b, 1'b0};
        if (!nine_in)
            fr[9] = stp;
        for (int i = 0; i < (nine_in ? 11 : 10); i++)
        begin
            line_out <= fr[i];
            repeat (clks) @(posedge clk_in);
        end
        line_out <= 1'b1;
    endtask

    // Samples each bit after the start bit at its centre, stop bit included.
    always
    begin
        @(negedge line_in);
        repeat (hear_clks_in / 2) @(posedge clk_in);
        for (int i = 0; i < (nine_in ? 10 : 9); i++)
        begin
            repeat (hear_clks_in) @(posedge clk_in);
            sh[i] = line_in;
        end
        got_byte_out = sh[7:0];
        got_ninth_out = nine_in & sh[8];
        got_stop_out = nine_in ? sh[9] : sh[8];
        got_cnt_out = got_cnt_out + 8'h01;
    end
endmodule

/* File: testbench/async_serial_port_modes_1_2_tb_top.sv */
/*
 * Self-checking bench of the serial port: APB master, far port, timeout.
 * Assumes the design answers APB with one wait state.
 */
`include "asp_consts.svh"

module async_serial_port_modes_1_2_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] CF [5] = '{12'h1D0, 12'h0D0, 12'hB90,
                                       12'hC90, 12'h190};
    localparam logic [7:0] R8 [5] = '{8'hFE, 8'hFE, 8'hFE, 8'hFE, 8'hFF};
    localparam logic [15:0] R16 [5] = '{16'hFFFE, 16'hFFFE, 16'hFFFE,
                                        16'hFFFF, 16'hFFFE};
    logic clk, rst_n, psel, pen, pwr, sin, pready, pslverr, sout, irq;
    logic err, nine, gn, gs, last_n;
    logic [7:0] paddr, gb, gc, rnd, own, last_b, r8;
    logic [15:0] hear, r16;
    logic [31:0] pwdata, prdata, rd, ctrl;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;

    asp_serial_port dut (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .SERIAL_IN_PIN_IN(sin), .SERIAL_OUT_PIN_OUT(sout), .IRQ_OUT(irq));

    asp_far_port far (.clk_in(clk), .line_in(sout), .nine_in(nine),
        .hear_clks_in(hear), .line_out(sin), .got_byte_out(gb),
        .got_ninth_out(gn), .got_stop_out(gs), .got_cnt_out(gc));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] g, e);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %0h want %0h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, e);
        chk({31'h0, g}, {31'h0, e});
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Bit period in system clocks for the current settings.
    function automatic int bclk(input logic wide);
        if (ctrl[`ASP_BIT_MODE9])
            return ctrl[`ASP_BIT_DOUBLER] ? 32 : 64;
        if (wide)
            return 32 * (65536 - r16);
        return 32 * (256 - r8) * (ctrl[11] ? 1 : 12) >> ctrl[8];
    endfunction

    function automatic logic exp_store(input logic [7:0] b,
                                       input logic n9, stp);
        if (!ctrl[`ASP_BIT_RX_ENABLE])
            return 1'b0;
        if (ctrl[`ASP_BIT_MODE9])
            return !ctrl[5] || (n9 && b == own);
        return !ctrl[5] || stp;
    endfunction

    task automatic rx_case(input logic [7:0] b, input logic n9, stp, clr);
        logic ok;
        ok = exp_store(b, n9, stp) && clr;
        if (clr)
            apb(1'b1, `ASP_ADDR_CTRL, ctrl);
        far.send(b, n9, stp, bclk(ctrl[10]));
        repeat (4) @(posedge clk);
        if (ok)
        begin
            last_b = b;
            last_n = ctrl[6] ? n9 : stp;
        end
        apb(1'b0, `ASP_ADDR_CTRL, 32'h0);
        chk1(rd[1], ok | !clr);
        chk1(rd[2], last_n);
        chk1(irq, ok | !clr);
        apb(1'b0, `ASP_ADDR_DATA, 32'h0);
        chk(rd, {24'h0, last_b});
    endtask

    task automatic tx_case(input logic [7:0] b, input logic n9);
        int t;
        int bc;
        logic [7:0] c0;
        bc = bclk(ctrl[9]);
        apb(1'b1, `ASP_ADDR_CTRL, ctrl | {28'h0, n9, 3'h0});
        c0 = gc;
        apb(1'b1, `ASP_ADDR_DATA, {24'h0, b});
        t = 0;
        while (irq !== 1'b1 && t < 4000)
        begin
            @(posedge clk);
            t++;
        end
        bc = bc * (ctrl[6] ? 10 : 9);
        chk1(t >= bc - bc / 144 - 2 && t <= bc + 3, 1'b1);
        chk1(sout, 1'b1);
        t = 0;
        while (gc === c0 && t < 4000)
        begin
            @(posedge clk);
            t++;
        end
        chk1(t < 4000, 1'b1);
        repeat (bclk(ctrl[9])) @(posedge clk);
        chk({24'h0, gb}, {24'h0, b});
        chk1(gn, ctrl[6] & n9);
        chk1(gs, 1'b1);
    endtask

    initial
    begin
        {psel, pen, pwr, rst_n, nine, last_n} = 6'h0;
        {paddr, pwdata, ctrl, last_b} = 80'h0;
        {r8, r16} = 24'hFEFFFE;
        rnd = 8'h4A;
        own = 8'h5A;
        hear = 16'h0020;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `ASP_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk1(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, `ASP_ADDR_OWN, {24'h0, own});
        for (int k = 0; k < 5; k++)
        begin
            r8 = R8[k];
            r16 = R16[k];
            apb(1'b1, `ASP_ADDR_RELOAD8, {24'h0, r8});
            apb(1'b1, `ASP_ADDR_RELOAD16, {16'h0, r16});
            apb(1'b0, `ASP_ADDR_RELOAD16, 32'h0);
            chk(rd, {16'h0, r16});
            ctrl = {20'h0, CF[k]};
            nine = ctrl[6];
            hear = 16'(bclk(ctrl[9]));
            rnd = lfsr(rnd);
            rx_case(rnd, rnd[0], !nine | rnd[1], 1'b1);
            apb(1'b1, `ASP_ADDR_CTRL, ctrl | 32'h3);
            apb(1'b0, `ASP_ADDR_CTRL, 32'h0);
            chk({30'h0, rd[1:0]}, 32'h2);
            rx_case(~rnd, 1'b1, 1'b1, 1'b0);
            rnd = lfsr(rnd);
            tx_case(rnd, rnd[2]);
        end
        ctrl = 32'h1F0;
        nine = 1'b1;
        hear = 16'h0020;
        rx_case(own, 1'b0, 1'b1, 1'b1);
        rx_case(8'h33, 1'b1, 1'b1, 1'b1);
        rx_case(own, 1'b1, 1'b0, 1'b1);
        r8 = 8'hFE;
        apb(1'b1, `ASP_ADDR_RELOAD8, {24'h0, r8});
        ctrl = 32'hBB0;
        nine = 1'b0;
        hear = 16'(bclk(ctrl[9]));
        rx_case(rnd, 1'b0, 1'b0, 1'b1);
        rx_case(rnd, 1'b0, 1'b1, 1'b1);
        ctrl = 32'hB80;
        rx_case(8'hC3, 1'b0, 1'b1, 1'b1);
        tally_and_finish();
    end
endmodule
